//--- pixel_lut_regs.svh
// Register offsets, field positions, reset values and table geometry for the pixel lookup block
`ifndef PIXEL_LUT_REGS_SVH
`define PIXEL_LUT_REGS_SVH

// Register byte offsets
`define LUT_MODE_OFS      8'h00
`define LUT_INDEX_OFS     8'h04
`define LUT_VALUE_OFS     8'h08
`define LUT_FORMAT_OFS    8'h0c
`define LUT_STATUS_OFS    8'h10

// Field positions
`define LUT_MODE_EN_BIT   0
`define LUT_FORMAT_8_BIT  0
`define LUT_STAT_EN_BIT   0
`define LUT_STAT_8_BIT    1

// Reset values
`define LUT_MODE_RST      1'b0
`define LUT_FORMAT_RST    1'b1
`define LUT_INDEX_RST     13'h0000

// Table geometry
`define LUT_ENTRIES       1025
`define LUT_TOP_INDEX     13'h1000
`define LUT_DROP_BITS     4

`endif

//--- pixel_lut_pkg.sv
// Types shared by the pixel lookup block
package pixel_lut_pkg;
  typedef logic [11:0] pixel12_t;
  typedef logic [7:0]  pixel8_t;
  typedef logic [7:0]  reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef logic [12:0] lut_index_t;
  typedef logic [10:0] lut_slot_t;
endpackage

//--- lut_interp.sv
// Linear interpolation stage between two table entries
`timescale 1ns/100ps
module lut_interp
  import pixel_lut_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rstn,
  // Operands
  input  wire logic    inValid,
  input  pixel_lut_pkg::pixel8_t lowEntry,
  input  pixel_lut_pkg::pixel8_t highEntry,
  input  wire logic [1:0] frac,
  // Result
  output logic         outValid,
  output pixel_lut_pkg::pixel8_t result
);
  logic signed [9:0]  diff;
  logic signed [11:0] scaled;
  logic signed [11:0] sum;

  // Lower + (high - low) * frac / 4, floored, stays in 0..255
  always_comb begin
    diff   = $signed({2'b00, highEntry}) - $signed({2'b00, lowEntry});
    scaled = 12'(diff * $signed({1'b0, frac}));
    sum    = $signed({4'h0, lowEntry}) + (scaled >>> 2); // R8
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      outValid <= 1'b0;
      result   <= 8'h00;
    end else begin
      outValid <= inValid;
      result   <= sum[7:0]; // R4 R8
    end
  end
endmodule // lut_interp

//--- pixel_lookup_table_12to8.sv
// Top of the 12-to-8 bit pixel converter with loadable lookup table
`timescale 1ns/100ps
`include "pixel_lut_regs.svh"

// How it works
// R1 - In 8-bit format with the table off, each pixel loses its four lowest bits.
// R2 - The table holds 1025 eight-bit entries at indices 0, 4, ... 4096.
// R3 - With the table on, a pixel equal to an index gives that index's entry.
// R4 - With the table on, other pixels interpolate between the nearest lower and higher entries.
// R5 - The top entry serves only as the upper point for pixels 4092 to 4095.
// R6 - Software writes an index first, then a value that lands at that index.
// R7 - Writing the enable value to the mode field switches truncation to table lookup. The code does so only while the format field selects 8-bit.
// R8 - Interpolation is lower plus difference times low two bits over four, truncated.
module pixel_lookup_table_12to8
  import pixel_lut_pkg::*;
#(
  parameter int ENTRIES = `LUT_ENTRIES
)
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Register port
  input  pixel_lut_pkg::reg_addr_t regAddr,
  input  pixel_lut_pkg::reg_data_t regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output pixel_lut_pkg::reg_data_t regRdata,
  // Sensor pixels in
  input  wire logic               pixInValid,
  input  pixel_lut_pkg::pixel12_t pixIn,
  // Pixels out
  output logic                    pixOutValid,
  output pixel_lut_pkg::pixel8_t  pixOut8,
  output pixel_lut_pkg::pixel12_t pixOut12
);
  import pixel_lut_pkg::*;

  // ==========================================================
  // Registers
  logic       lutEnable_reg;
  logic       format8_reg;
  lut_index_t index_reg;
  reg_data_t  rdata_reg;
  pixel8_t    table_mem [ENTRIES];

  function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
    return a == ofs;
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lutEnable_reg <= `LUT_MODE_RST;
      format8_reg   <= `LUT_FORMAT_RST;
    end else if (regWr) begin
      if (hit(regAddr, `LUT_MODE_OFS))
        lutEnable_reg <= regWdata[`LUT_MODE_EN_BIT]; // R7
      if (hit(regAddr, `LUT_FORMAT_OFS))
        format8_reg <= regWdata[`LUT_FORMAT_8_BIT];
    end
  end

  // Indices beyond the top one are clamped so a value write never escapes the table
  always_ff @(posedge clk) begin
    if (!rstn) begin
      index_reg <= `LUT_INDEX_RST;
    end else if (regWr && hit(regAddr, `LUT_INDEX_OFS)) begin
      if (regWdata[12:0] > `LUT_TOP_INDEX)
        index_reg <= `LUT_TOP_INDEX;
      else
        index_reg <= regWdata[12:0]; // R6
    end
  end

  // Table storage, one slot per multiple of four
  always_ff @(posedge clk) begin
    if (regWr && hit(regAddr, `LUT_VALUE_OFS))
      table_mem[index_reg[12:2]] <= regWdata[7:0]; // R2 R6
  end

  // Read data one cycle after the strobe, zero otherwise and for unmapped offsets
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        `LUT_MODE_OFS:   rdata_reg <= {31'h0, lutEnable_reg};
        `LUT_INDEX_OFS:  rdata_reg <= {19'h0, index_reg};
        `LUT_VALUE_OFS:  rdata_reg <= {24'h0, table_mem[index_reg[12:2]]};
        `LUT_FORMAT_OFS: rdata_reg <= {31'h0, format8_reg};
        `LUT_STATUS_OFS: rdata_reg <= {30'h0, format8_reg, lutEnable_reg};
        default:         rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end
  assign regRdata = rdata_reg;

  // ==========================================================
  // Pixel path, stage 1: table fetch
  logic      s1Valid_reg;
  pixel8_t   s1Low_reg;
  pixel8_t   s1High_reg;
  logic [1:0] s1Frac_reg;
  pixel8_t   s1Trunc_reg;
  pixel12_t  s1Raw_reg;
  logic      s1Lut_reg;
  lut_slot_t lowSlot;
  lut_slot_t highSlot;

  // Upper point is the next slot; for 4092..4095 that is the top entry
  always_comb begin
    lowSlot  = {1'b0, pixIn[11:2]};
    highSlot = 11'(lowSlot + 11'h001); // R5
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1Valid_reg <= 1'b0;
      s1Low_reg   <= 8'h00;
      s1High_reg  <= 8'h00;
      s1Frac_reg  <= 2'b00;
      s1Trunc_reg <= 8'h00;
      s1Raw_reg   <= 12'h000;
      s1Lut_reg   <= 1'b0;
    end else begin
      s1Valid_reg <= pixInValid;
      s1Low_reg   <= table_mem[lowSlot]; // R3
      s1High_reg  <= table_mem[highSlot]; // R4 R5
      s1Frac_reg  <= pixIn[1:0];
      s1Trunc_reg <= pixIn[11:`LUT_DROP_BITS]; // R1
      s1Raw_reg   <= pixIn;
      s1Lut_reg   <= lutEnable_reg && format8_reg; // R7
    end
  end

  // ==========================================================
  // Stage 2: interpolation, with matching delay on the bypass
  logic    s2Valid;
  pixel8_t s2Interp;
  pixel8_t s2Trunc_reg;
  pixel12_t s2Raw_reg;
  logic    s2Lut_reg;

  lut_interp u_interp (
    .clk       (clk),
    .rstn      (rstn),
    .inValid   (s1Valid_reg),
    .lowEntry  (s1Low_reg),
    .highEntry (s1High_reg),
    .frac      (s1Frac_reg),
    .outValid  (s2Valid),
    .result    (s2Interp)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s2Trunc_reg <= 8'h00;
      s2Raw_reg   <= 12'h000;
      s2Lut_reg   <= 1'b0;
    end else begin
      s2Trunc_reg <= s1Trunc_reg;
      s2Raw_reg   <= s1Raw_reg;
      s2Lut_reg   <= s1Lut_reg;
    end
  end

  // ==========================================================
  // Output stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pixOutValid <= 1'b0;
      pixOut8     <= 8'h00;
      pixOut12    <= 12'h000;
    end else begin
      pixOutValid <= s2Valid;
      pixOut8     <= s2Lut_reg ? s2Interp : s2Trunc_reg; // R1 R3 R4
      pixOut12    <= s2Raw_reg;
    end
  end
endmodule // pixel_lookup_table_12to8

//--- pixel_lut_assertions.sv
// Checker for the pixel lookup block ports
`timescale 1ns/100ps
`include "pixel_lut_regs.svh"
// ====
// Port checker
module pixel_lut_assertions
  import pixel_lut_pkg::*;
#(parameter int ENTRIES = 1025)
(
  input wire logic clk, rstn, regWr, regRd, pixInValid, pixOutValid,
  input pixel_lut_pkg::reg_addr_t regAddr,
  input pixel_lut_pkg::reg_data_t regWdata, regRdata,
  input pixel_lut_pkg::pixel12_t pixIn, pixOut12,
  input pixel_lut_pkg::pixel8_t pixOut8
);
  logic modeH, fmtH;
  logic [12:0] idxH;
  logic [1:0] up;
  // Shadow of the control fields
  always_ff @(posedge clk) begin
    if (!rstn) begin
      modeH <= 1'b0; fmtH <= 1'b1; idxH <= 13'h0; up <= 2'h0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (regWr && regAddr == `LUT_MODE_OFS) modeH <= regWdata[0];
      if (regWr && regAddr == `LUT_FORMAT_OFS) fmtH <= regWdata[0];
      if (regWr && regAddr == `LUT_INDEX_OFS)
        idxH <= (regWdata[12:0] > 13'h1000) ? 13'h1000 : regWdata[12:0];
    end
  end
  sequence rdAt(reg_addr_t a);
    regRd && regAddr == a;
  endsequence
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  valid_delay_a: assert property (up == 2'h3 |-> pixOutValid == $past(pixInValid, 3))
    else $error("valid delay");
  raw_delay_a: assert property (up == 2'h3 && pixOutValid |-> pixOut12 == $past(pixIn, 3))
    else $error("raw pixel delay");
  trunc_path_a: assert property (up == 2'h3 && pixOutValid && !$past(modeH && fmtH, 3)
    |-> pixOut8 == $past(pixIn[11:4], 3)) else $error("truncation");
  rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0) else $error("rdata");
  status_read_a: assert property (rdAt(`LUT_STATUS_OFS) |=> regRdata == {30'h0, fmtH, modeH})
    else $error("status");
  mode_read_a: assert property (rdAt(`LUT_MODE_OFS) |=> regRdata == {31'h0, modeH})
    else $error("mode");
  index_read_a: assert property (rdAt(`LUT_INDEX_OFS) |=> regRdata == {19'h0, idxH})
    else $error("index");
  unmapped_read_a: assert property (rdAt(8'h14) |=> regRdata == 32'h0) else $error("unmapped");
  reset_out_a: assert property (disable iff (1'b0) !rstn |=> !pixOutValid && pixOut8 == 8'h0
    && regRdata == 32'h0) else $error("reset outputs");
endmodule // pixel_lut_assertions

bind pixel_lookup_table_12to8 pixel_lut_assertions #(.ENTRIES(ENTRIES)) pixel_lut_assertions_i (
  .clk(clk), .rstn(rstn), .regWr(regWr), .regRd(regRd), .pixInValid(pixInValid),
  .pixOutValid(pixOutValid), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .pixIn(pixIn), .pixOut12(pixOut12), .pixOut8(pixOut8));

//--- pixel_source_model.sv
// Sensor pixel source model
`timescale 1ns/100ps
// ====
// Source
module pixel_source_model
  import pixel_lut_pkg::*;
(
  input wire logic clk, reqValid,
  input pixel_lut_pkg::pixel12_t reqPix,
  output logic pixInValid,
  output pixel_lut_pkg::pixel12_t pixIn
);
  initial begin
    pixInValid = 1'b0;
    pixIn = 12'h0;
  end
  // Idle cycles invert the previous pixIn, so the last pixel returns on every second one
  always @(posedge clk) begin
    pixInValid <= reqValid;
    pixIn <= reqValid ? reqPix : ~pixIn;
  end
endmodule // pixel_source_model

//--- pixel_lookup_table_12to8_bench.sv
// Self-checking bench for the pixel lookup block
`timescale 1ns/100ps
`include "pixel_lut_regs.svh"
// ====
// Bench
module pixel_lookup_table_12to8_bench;
  import pixel_lut_pkg::*;
  logic clk, rstn, regWr, regRd, reqValid, pixInValid, pixOutValid, modeOn, fmt8;
  reg_addr_t regAddr;
  reg_data_t regWdata, regRdata;
  pixel12_t reqPix, pixIn, pixOut12;
  pixel8_t pixOut8, tbl [1025], q [$];
  pixel12_t r [$];
  int bad_count, checks_done, seed, i;
  pixel_lookup_table_12to8 #(.ENTRIES(1025)) pixel_lookup_table_12to8_i (.clk(clk),
    .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .pixInValid(pixInValid), .pixIn(pixIn), .pixOutValid(pixOutValid),
    .pixOut8(pixOut8), .pixOut12(pixOut12));
  pixel_source_model pixel_source_model_i (.clk(clk), .reqValid(reqValid), .reqPix(reqPix),
    .pixInValid(pixInValid), .pixIn(pixIn));
  function automatic pixel8_t expv(pixel12_t p);
    int k, lo, hi;
    k = p[11:2];
    lo = tbl[k];
    hi = tbl[k + 1];
    if (!(modeOn && fmt8)) return p[11:4];
    return pixel8_t'(lo + (((hi - lo) * int'(p[1:0])) >>> 2));
  endfunction
  task chk(input string n, input reg_data_t e, input reg_data_t g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input reg_addr_t a, input reg_data_t d);
    @(posedge clk); regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge clk); regWr <= 1'b0;
  endtask
  task rd(input reg_addr_t a, input reg_data_t e, input string n);
    @(posedge clk); regRd <= 1'b1; regAddr <= a;
    @(posedge clk); regRd <= 1'b0;
    #1 chk(n, e, regRdata);
  endtask
  task px(input pixel12_t p);
    @(posedge clk); reqValid <= 1'b1; reqPix <= p;
  endtask
  task run(input string n);
    for (i = 0; i < 300; i++) px(pixel12_t'($random(seed)));
    foreach (tbl[j]) if (j > 1020) px(pixel12_t'(j + 3070));
    px(12'h0); px(12'h9); px(12'h4);
    px(12'hffc); px(12'hfff);
    @(posedge clk); reqValid <= 1'b0;
    repeat (8) @(posedge clk);
    $display("test %s done", n);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rstn && pixInValid === 1'b1) begin
      q.push_back(expv(pixIn));
      r.push_back(pixIn);
    end
    #1 if (pixOutValid === 1'b1) begin
      chk("pixOut8", q.pop_front(), pixOut8);
      chk("pixOut12", r.pop_front(), pixOut12);
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000 bad_count++;
    final_report;
  end
  initial begin
    rstn = 0; regWr = 0; regRd = 0; regAddr = 0; regWdata = 0; reqValid = 0; reqPix = 0;
    modeOn = 0; fmt8 = 1; seed = 32'he24e; bad_count = 0; checks_done = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(`LUT_STATUS_OFS, 32'h2, "status");
    rd(8'h14, 32'h0, "unmapped");
    run("truncate");
    for (i = 0; i < 1025; i++) begin
      tbl[i] = pixel8_t'($random(seed));
      wr(`LUT_INDEX_OFS, reg_data_t'(i * 4));
      wr(`LUT_VALUE_OFS, {24'h0, tbl[i]});
    end
    wr(`LUT_INDEX_OFS, 32'h1fff);
    rd(`LUT_INDEX_OFS, 32'h1000, "index");
    rd(`LUT_VALUE_OFS, {24'h0, tbl[1024]}, "value");
    wr(`LUT_MODE_OFS, 32'h1); modeOn = 1;
    rd(`LUT_STATUS_OFS, 32'h3, "status");
    run("table");
    wr(`LUT_FORMAT_OFS, 32'h0); fmt8 = 0;
    rd(`LUT_STATUS_OFS, 32'h1, "status");
    run("format");
    final_report;
  end
endmodule // pixel_lookup_table_12to8_bench
